// file: src/can_bit_timing.sv
// can bit timing and synchronisation: quantum prescaler, four-segment bit,
// sample point with optional triple sampling, hard sync and resync
// assumes framing logic supplies bus_idle_i and tx_bit_i on clk_i
// assumes can_rx_i is asynchronous to clk_i
module can_bit_timing
	import can_timing_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic can_rx_i,
	output logic can_tx_o,
	input wire logic tx_bit_i,
	input wire logic bus_idle_i,
	output logic bit_start_o,
	output logic sample_point_o,
	output logic sampled_bit_o,
	output logic hard_sync_o,
	output logic resync_o
);

	// register file
	logic [15:0] timing_config_one;
	logic [15:0] timing_config_two;
	logic [15:0] control;
	logic [15:0] next_timing_config_one;
	logic [15:0] next_timing_config_two;
	logic [15:0] next_control;
	logic [15:0] next_rdata;
	logic [15:0] status;
	timing_cfg_s cfg;

	// receive pin synchroniser and edge detect
	logic rx_meta;
	logic rx_sync;
	logic rx_prev;
	logic falling;

	// bit timing state
	seg_e seg;
	logic [4:0] tq_cnt;
	logic [4:0] bit_pos;
	logic [2:0] ph1_ext;
	logic [2:0] ph2_cut;
	logic synced;
	logic tx_q;
	seg_e next_seg;
	logic [4:0] next_tq_cnt;
	logic [4:0] next_bit_pos;
	logic [2:0] next_ph1_ext;
	logic [2:0] next_ph2_cut;
	logic next_synced;
	logic next_tx;

	// event pulses, all but restart registered onto the outputs
	logic ev_bit_start;
	logic ev_sample;
	logic ev_hard;
	logic ev_resync;
	logic restart;

	// derived lengths in quanta
	logic [4:0] prop_len;
	logic [4:0] ph1_base;
	logic [4:0] ph1_len;
	logic [4:0] ph2_base;
	logic [4:0] ph2_len;
	logic [4:0] sjw_len;
	logic [4:0] seg_len;
	logic [4:0] err_neg;
	logic seg_last;
	logic half_tick;
	logic tq_tick;

	assign cfg.quantum_prescaler = timing_config_one[PRESCALER_LSB +: 6];
	assign cfg.jump_width = timing_config_one[JUMP_WIDTH_LSB +: 2];
	assign cfg.prop_segment_len = timing_config_two[PROP_LEN_LSB +: 3];
	assign cfg.phase1_len = timing_config_two[PHASE1_LEN_LSB +: 3];
	assign cfg.phase2_len = timing_config_two[PHASE2_LEN_LSB +: 3];
	assign cfg.phase2_free = timing_config_two[PHASE2_FREE_BIT];
	assign cfg.triple_sample_enable = timing_config_two[TRIPLE_SAMPLE_BIT];
	assign cfg.module_clock_select = control[CLOCK_SELECT_BIT];

	// register access
	// status is read only; a write to it falls to the default branch
	always_comb begin
		next_timing_config_one = timing_config_one;
		next_timing_config_two = timing_config_two;
		next_control = control;
		if (wr_i) begin
			case (addr_i)
				OFS_TIMING_CONFIG_ONE: begin
					next_timing_config_one = wdata_i & CFG_ONE_MASK;
				end
				OFS_TIMING_CONFIG_TWO: begin
					next_timing_config_two = wdata_i & CFG_TWO_MASK;
				end
				OFS_CONTROL: begin
					next_control = wdata_i & CONTROL_MASK;
				end
				default: begin
					next_control = control;
				end
			endcase
		end
		status = 16'h0000;
		status[STAT_SEG_LSB +: 2] = seg;
		status[STAT_BIT_BIT] = sampled_bit_o;
		status[STAT_RX_BIT] = rx_sync;
		status[STAT_SYNCED_BIT] = synced;
		status[STAT_POS_LSB +: 5] = bit_pos;
		next_rdata = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				OFS_TIMING_CONFIG_ONE: next_rdata = timing_config_one;
				OFS_TIMING_CONFIG_TWO: next_rdata = timing_config_two;
				OFS_CONTROL: next_rdata = control;
				OFS_STATUS: next_rdata = status;
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timing_config_one <= CFG_ONE_RST;
			timing_config_two <= CFG_TWO_RST;
			control <= CONTROL_RST;
			rdata_o <= 16'h0000;
		end else begin
			timing_config_one <= next_timing_config_one;
			timing_config_two <= next_timing_config_two;
			control <= next_control;
			rdata_o <= next_rdata;
		end
	end

	// receive pin synchroniser; rx_prev follows the second stage only
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= can_rx_i;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	assign falling = rx_prev & ~rx_sync;

	tq_prescaler u_prescaler (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.restart_i(restart),
		.module_clock_select_i(cfg.module_clock_select),
		.quantum_prescaler_i(cfg.quantum_prescaler),
		.half_tick_o(half_tick),
		.tq_tick_o(tq_tick)
	);

	majority_sampler u_sampler (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.rx_i(rx_sync),
		.half_tick_i(half_tick),
		.sample_i(ev_sample),
		.triple_i(cfg.triple_sample_enable),
		.bit_o(sampled_bit_o)
	);

	// segment lengths, each field holding length minus one
	always_comb begin
		prop_len = {2'b00, cfg.prop_segment_len} + 5'h01;
		ph1_base = {2'b00, cfg.phase1_len} + 5'h01;
		ph1_len = ph1_base + {2'b00, ph1_ext};
		sjw_len = {3'b000, cfg.jump_width} + 5'h01;
		if (cfg.phase2_free) begin
			ph2_base = {2'b00, cfg.phase2_len} + 5'h01;
		end else begin
			ph2_base = (ph1_base > PROC_TIME_TQ) ? ph1_base : PROC_TIME_TQ;
		end
		// a cut never takes phase two below one quantum
		ph2_len = (ph2_base > {2'b00, ph2_cut}) ? ph2_base - {2'b00, ph2_cut} : 5'h01;
		case (seg)
			SEG_SYNC: seg_len = SYNC_LEN_TQ;
			SEG_PROP: seg_len = prop_len;
			SEG_PH1: seg_len = ph1_len;
			SEG_PH2: seg_len = ph2_len;
			default: seg_len = SYNC_LEN_TQ;
		endcase
		seg_last = (tq_cnt == seg_len - 5'h01);
		// quanta left until the next sync segment
		err_neg = ph2_len - tq_cnt;
	end

	// segment sequencer and synchronisation
	always_comb begin
		next_seg = seg;
		next_tq_cnt = tq_cnt;
		next_bit_pos = bit_pos;
		next_ph1_ext = ph1_ext;
		next_ph2_cut = ph2_cut;
		next_synced = synced;
		next_tx = tx_q;
		ev_bit_start = 1'b0;
		ev_sample = 1'b0;
		ev_hard = 1'b0;
		ev_resync = 1'b0;
		restart = 1'b0;
		if (tq_tick) begin
			next_tq_cnt = tq_cnt + 5'h01;
			if (bit_pos != MAX_POS_TQ) begin
				next_bit_pos = bit_pos + 5'h01;
			end
			if (seg_last) begin
				next_tq_cnt = 5'h00;
				case (seg)
					SEG_SYNC: next_seg = SEG_PROP;
					SEG_PROP: next_seg = SEG_PH1;
					SEG_PH1: begin
						next_seg = SEG_PH2;
						ev_sample = 1'b1;
					end
					SEG_PH2: begin
						next_seg = SEG_SYNC;
						next_bit_pos = 5'h00;
						next_ph1_ext = 3'h0;
						next_ph2_cut = 3'h0;
						next_synced = 1'b0;
						next_tx = tx_bit_i;
						ev_bit_start = 1'b1;
					end
					default: next_seg = SEG_SYNC;
				endcase
			end
		end
		if (falling && bus_idle_i) begin
			restart = 1'b1;
			ev_hard = 1'b1;
		end else if (falling && !synced) begin
			// edge position in whole quanta, seen two clocks after the pin moves
			ev_resync = 1'b1;
			next_synced = 1'b1;
			case (seg)
				SEG_SYNC: next_synced = 1'b1;
				SEG_PROP, SEG_PH1: begin
					if (bit_pos <= sjw_len) begin
						restart = 1'b1;
					end else begin
						next_ph1_ext = cfg.jump_width + 3'h1;
						if (seg == SEG_PH1 && tq_tick && seg_last) begin
							// stretch lands on the last quantum: stay in phase one, no sample yet
							next_seg = SEG_PH1;
							next_tq_cnt = tq_cnt + 5'h01;
							ev_sample = 1'b0;
						end
					end
				end
				SEG_PH2: begin
					if (err_neg <= sjw_len) begin
						restart = 1'b1;
					end else begin
						next_ph2_cut = cfg.jump_width + 3'h1;
					end
				end
				default: next_synced = 1'b1;
			endcase
		end
		if (restart) begin
			// the edge now lies inside the sync segment of a fresh bit
			next_seg = SEG_SYNC;
			next_tq_cnt = 5'h00;
			next_bit_pos = 5'h00;
			next_ph1_ext = 3'h0;
			next_ph2_cut = 3'h0;
			next_synced = 1'b1;
			next_tx = tx_bit_i;
			ev_bit_start = 1'b1;
			ev_sample = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seg <= SEG_SYNC;
			tq_cnt <= 5'h00;
			bit_pos <= 5'h00;
			ph1_ext <= 3'h0;
			ph2_cut <= 3'h0;
			synced <= 1'b0;
			tx_q <= 1'b1;
			bit_start_o <= 1'b0;
			sample_point_o <= 1'b0;
			hard_sync_o <= 1'b0;
			resync_o <= 1'b0;
		end else begin
			seg <= next_seg;
			tq_cnt <= next_tq_cnt;
			bit_pos <= next_bit_pos;
			ph1_ext <= next_ph1_ext;
			ph2_cut <= next_ph2_cut;
			synced <= next_synced;
			tx_q <= next_tx;
			bit_start_o <= ev_bit_start;
			sample_point_o <= ev_sample;
			hard_sync_o <= ev_hard;
			resync_o <= ev_resync;
		end
	end

	assign can_tx_o = tx_q;

endmodule // can_bit_timing

// file: src/can_timing_pkg.sv
// package of the can bit timing block: register map, field positions,
// reset values, segment states and the configuration carrier
// assumes a 16-bit register port and a single clock domain
package can_timing_pkg;

	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;

	// register offsets (word index on the plain register port)
	localparam logic [3:0] OFS_TIMING_CONFIG_ONE = 4'h0;
	localparam logic [3:0] OFS_TIMING_CONFIG_TWO = 4'h1;
	localparam logic [3:0] OFS_CONTROL = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;

	// field positions in timing_config_one
	localparam int unsigned PRESCALER_LSB = 0;
	localparam int unsigned JUMP_WIDTH_LSB = 6;
	// field positions in timing_config_two
	localparam int unsigned PROP_LEN_LSB = 0;
	localparam int unsigned PHASE1_LEN_LSB = 3;
	localparam int unsigned TRIPLE_SAMPLE_BIT = 6;
	localparam int unsigned PHASE2_FREE_BIT = 7;
	localparam int unsigned PHASE2_LEN_LSB = 8;
	// field positions in control
	localparam int unsigned CLOCK_SELECT_BIT = 0;
	// field positions in status
	localparam int unsigned STAT_SEG_LSB = 0;
	localparam int unsigned STAT_BIT_BIT = 2;
	localparam int unsigned STAT_RX_BIT = 3;
	localparam int unsigned STAT_SYNCED_BIT = 4;
	localparam int unsigned STAT_POS_LSB = 5;

	// writable bits of each register, others read as zero
	localparam logic [15:0] CFG_ONE_MASK = 16'h00ff;
	localparam logic [15:0] CFG_TWO_MASK = 16'h07ff;
	localparam logic [15:0] CONTROL_MASK = 16'h0001;

	// values after reset
	localparam logic [15:0] CFG_ONE_RST = 16'h0000;
	localparam logic [15:0] CFG_TWO_RST = 16'h0000;
	localparam logic [15:0] CONTROL_RST = 16'h0000;

	// segment lengths and bit position limit in quanta
	localparam logic [4:0] SYNC_LEN_TQ = 5'h01;
	localparam logic [4:0] PROC_TIME_TQ = 5'h03;
	localparam logic [4:0] MAX_POS_TQ = 5'h1f;
	// module clock divider when the cpu-rate clock is selected
	localparam logic [1:0] CPU_RATE_DIV_LAST = 2'h3;

	typedef enum logic [1:0] {
		SEG_SYNC = 2'b00,
		SEG_PROP = 2'b01,
		SEG_PH1 = 2'b10,
		SEG_PH2 = 2'b11
	} seg_e;

	typedef struct packed {
		logic [5:0] quantum_prescaler;
		logic [1:0] jump_width;
		logic [2:0] prop_segment_len;
		logic [2:0] phase1_len;
		logic [2:0] phase2_len;
		logic phase2_free;
		logic triple_sample_enable;
		logic module_clock_select;
	} timing_cfg_s;

endpackage

// file: src/tq_prescaler.sv
// time quantum prescaler: half-quantum and quantum ticks from clk_i
// assumes clk_i is the quadrupled rate; restart_i realigns the quantum
module tq_prescaler
	import can_timing_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic restart_i,
	input wire logic module_clock_select_i,
	input wire logic [5:0] quantum_prescaler_i,
	output logic half_tick_o,
	output logic tq_tick_o
);

	logic [1:0] quad_cnt;
	logic [5:0] half_cnt;
	logic half_phase;
	logic [1:0] next_quad_cnt;
	logic [5:0] next_half_cnt;
	logic next_half_phase;
	logic mod_tick;

	always_comb begin
		// module clock is clk_i, or clk_i divided by four when selected
		mod_tick = module_clock_select_i ? (quad_cnt == CPU_RATE_DIV_LAST) : 1'b1;
		half_tick_o = mod_tick && (half_cnt == quantum_prescaler_i);
		tq_tick_o = half_tick_o && half_phase;
		next_quad_cnt = quad_cnt + 2'h1;
		next_half_cnt = half_cnt;
		next_half_phase = half_phase;
		if (mod_tick) begin
			next_half_cnt = half_tick_o ? 6'h00 : half_cnt + 6'h01;
		end
		if (half_tick_o) begin
			next_half_phase = ~half_phase;
		end
		if (restart_i) begin
			next_quad_cnt = 2'h0;
			next_half_cnt = 6'h00;
			next_half_phase = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			quad_cnt <= 2'h0;
			half_cnt <= 6'h00;
			half_phase <= 1'b0;
		end else begin
			quad_cnt <= next_quad_cnt;
			half_cnt <= next_half_cnt;
			half_phase <= next_half_phase;
		end
	end

endmodule // tq_prescaler

// file: src/majority_sampler.sv
// bus sampler: one sample, or majority of three taken half a quantum apart
// assumes rx_i is already synchronised to clk_i
module majority_sampler
	import can_timing_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic rx_i,
	input wire logic half_tick_i,
	input wire logic sample_i,
	input wire logic triple_i,
	output logic bit_o
);

	logic [1:0] early;
	logic [1:0] next_early;
	logic next_bit;
	logic vote;

	always_comb begin
		next_early = early;
		if (half_tick_i) begin
			next_early = {early[0], rx_i};
		end
		vote = (rx_i & early[0]) | (rx_i & early[1]) | (early[0] & early[1]);
		next_bit = bit_o;
		if (sample_i) begin
			next_bit = triple_i ? vote : rx_i;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			early <= 2'h3;
			bit_o <= 1'b1;
		end else begin
			early <= next_early;
			bit_o <= next_bit;
		end
	end

endmodule // majority_sampler

// file: tb/can_bit_timing_checker.sv
// checker of the can bit timing block: timing pulses and read port
// assumes it is bound to can_bit_timing on a single clock
module can_bit_timing_checker
	import can_timing_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic can_rx_i,
	input wire logic can_tx_o,
	input wire logic tx_bit_i,
	input wire logic bus_idle_i,
	input wire logic bit_start_o,
	input wire logic sample_point_o,
	input wire logic sampled_bit_o,
	input wire logic hard_sync_o,
	input wire logic resync_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// set for the whole bit that began with a hard sync
	logic hs_bit;
	logic next_hs_bit;
	always_comb begin
		next_hs_bit = hs_bit;
		if (bit_start_o) begin
			next_hs_bit = hard_sync_o;
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hs_bit <= 1'b0;
		end else begin
			hs_bit <= next_hs_bit;
		end
	end
	AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == '0)
		else $error("read data not zero outside a read");
	AST_SP_GAP: assert property (sample_point_o |=> !sample_point_o [*4])
		else $error("sample points too close");
	AST_START_SP: assert property (bit_start_o |=> !sample_point_o [*4])
		else $error("sample point too soon after bit start");
	AST_SAMPLED_AT_SP: assert property ($changed(sampled_bit_o) |-> sample_point_o)
		else $error("sampled bit changed off the sample point");
	AST_HARD_START: assert property (hard_sync_o |-> bit_start_o)
		else $error("hard sync without bit start");
	AST_HARD_IDLE: assert property (hard_sync_o |-> $past(bus_idle_i))
		else $error("hard sync while bus busy");
	AST_FALL_ONLY: assert property ((hard_sync_o || resync_o) |-> !$past(can_rx_i, 3))
		else $error("sync without dominant line");
	AST_NO_RESYNC_HS: assert property (resync_o |-> !hs_bit)
		else $error("resync in a hard synced bit");
	AST_TX_AT_START: assert property ($changed(can_tx_o) |-> bit_start_o || $past(bit_start_o))
		else $error("transmit pin changed mid bit");
	COV_HARD: cover property (hard_sync_o);
	COV_RESYNC: cover property (resync_o);
	COV_SP_LOW: cover property (sample_point_o && !sampled_bit_o);
endmodule // can_bit_timing_checker

bind can_bit_timing can_bit_timing_checker chk (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .can_rx_i(can_rx_i),
	.can_tx_o(can_tx_o), .tx_bit_i(tx_bit_i), .bus_idle_i(bus_idle_i), .bit_start_o(bit_start_o),
	.sample_point_o(sample_point_o), .sampled_bit_o(sampled_bit_o), .hard_sync_o(hard_sync_o),
	.resync_o(resync_o));

// file: tb/can_node.sv
// model of the other bus nodes: drives the shared receive line
// assumes hold is called right after a rising clock edge
module can_node (
	input wire logic clk_i,
	output logic rx_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial rx_o = 1'b1;
	// levels last n whole clock cycles and edges come within six bits
	task automatic hold(input logic v, input int n);
		rx_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
endmodule // can_node

// file: tb/can_bit_timing_bench.sv
// testbench of the can bit timing block: registers, bit length, sync
// assumes can_node drives the receive line; 40 MHz clock
module can_bit_timing_bench
	import can_timing_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TMO = 20000;
	localparam int Q = 8;
	localparam int BIT = 11 * Q;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic tx_bit_i = 1'b1;
	logic bus_idle_i = 1'b1;
	logic can_rx;
	logic [15:0] rdata_o;
	logic can_tx_o, bit_start_o, sample_point_o, sampled_bit_o, hard_sync_o, resync_o;
	int cyc = 0;
	int error_cnt = 0;
	int checks = 0;
	int st[$];
	int sp[$];
	always #12.5 clk_i = ~clk_i;
	can_node node (.clk_i(clk_i), .rx_o(can_rx));
	can_bit_timing DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .can_rx_i(can_rx), .can_tx_o(can_tx_o),
		.tx_bit_i(tx_bit_i), .bus_idle_i(bus_idle_i), .bit_start_o(bit_start_o),
		.sample_point_o(sample_point_o), .sampled_bit_o(sampled_bit_o),
		.hard_sync_o(hard_sync_o), .resync_o(resync_o));
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// bit starts and sample points counted from the last hard sync
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (hard_sync_o) begin
			st.delete();
			sp.delete();
		end
		if (bit_start_o) st.push_back(cyc);
		if (sample_point_o) sp.push_back(cyc);
		if (cyc == TMO) begin
			error_cnt++;
			give_verdict();
		end
	end
	task automatic cmp(input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 cmp(rdata_o, e);
		@(posedge clk_i);
	endtask
	task automatic t_regs();
		rd(OFS_TIMING_CONFIG_ONE, 16'h0000);
		rd(OFS_TIMING_CONFIG_TWO, 16'h0000);
		rd(OFS_CONTROL, 16'h0000);
		wr(OFS_TIMING_CONFIG_ONE, 16'hffff);
		wr(OFS_TIMING_CONFIG_TWO, 16'hffff);
		wr(OFS_CONTROL, 16'hffff);
		wr(4'h9, 16'hffff);
		rd(OFS_TIMING_CONFIG_ONE, 16'h00ff);
		rd(OFS_TIMING_CONFIG_TWO, 16'h07ff);
		rd(OFS_CONTROL, 16'h0001);
		rd(4'h9, 16'h0000);
		$display("test regs done");
	endtask
	// hard sync then a bit measured between bit start pulses
	task automatic period(input logic [15:0] c1, c2, input int eb, es);
		wr(OFS_TIMING_CONFIG_ONE, c1);
		wr(OFS_TIMING_CONFIG_TWO, c2);
		tx_bit_i <= 1'b0;
		node.hold(1'b0, 8);
		bus_idle_i <= 1'b0;
		node.hold(1'b0, 16);
		node.hold(1'b1, 2 * eb);
		bus_idle_i <= 1'b1;
		cmp(16'(st[1] - st[0]), 16'(eb));
		cmp(16'(sp[0] - st[0]), 16'(es));
		cmp({15'h0000, sampled_bit_o}, 16'h0001);
		cmp({15'h0000, can_tx_o}, 16'h0000);
		tx_bit_i <= 1'b1;
		$display("test period done");
	endtask
	// hard sync, ignored edge in that bit, then one edge d clocks into bit two
	task automatic frame(input logic [15:0] c1, input int d);
		wr(OFS_TIMING_CONFIG_ONE, c1);
		node.hold(1'b0, 8);
		bus_idle_i <= 1'b0;
		node.hold(1'b0, 12);
		node.hold(1'b1, 20);
		node.hold(1'b0, 46);
		rd(OFS_STATUS, 16'h0153);
		cmp({15'h0000, sampled_bit_o}, 16'h0000);
		node.hold(1'b1, d);
		node.hold(1'b0, 40);
		node.hold(1'b1, 200);
		bus_idle_i <= 1'b1;
		cmp(16'(st[1] - st[0]), 16'(BIT));
	endtask
	task automatic t_pos();
		frame(16'h0040, 36);
		cmp(16'(st[2] - st[1]), 16'(BIT + 2 * Q));
		$display("test positive error done");
	endtask
	task automatic t_neg();
		frame(16'h0040, 60);
		cmp(16'(st[2] - st[1]), 16'(BIT - 2 * Q));
		$display("test negative error done");
	endtask
	task automatic t_restart();
		frame(16'h0000, 12);
		cmp(16'(st[2] - st[1]), 16'(12));
		$display("test small error done");
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		wr(OFS_CONTROL, 16'h0000);
		period(16'h0001, 16'h0003, 9 * 4, 6 * 4);
		wr(OFS_CONTROL, 16'h0001);
		period(16'h0001, 16'h0003, 9 * 16, 6 * 16);
		period(16'h0002, 16'h0061, 13 * 24, 8 * 24);
		wr(OFS_TIMING_CONFIG_TWO, 16'h0399);
		t_pos();
		t_neg();
		t_restart();
		give_verdict();
	end
endmodule // can_bit_timing_bench
